// [verilog/vdsd_pkg.sv]
// constants, types and helper functions for the vme dram slave decoder
// ----------------------------------------------------------------------------
// Overview of operation
// - the window size strap codes 0000, 0001, 0011, 0111 and 1111 open a 1, 2, 4, 8, 16 MB window.
// - in the variant build the window strap narrows only the a24 window, a32 sees all dram.
// - a base must be aligned to the full installed dram size; 4 MB allows 0, 4, 8 or C (x1 MB).
// - with 8 MB fitted the a24 base may only be zero or 0x80_0000.
// - with 12 or 16 MB fitted the a24 base must be zero.
// - a24 addresses are compared against a four-bit base strap holding a20..a23.
// - a32 base bits a24..a31 come from an eight-bit base strap.
// - a strap bit is 0 when its jumper is fitted and 1 when it is absent.
// - in the standard build the a32 base is the a32 strap plus the a24 base strap.
// - in the variant build the a32 base comes from the a32 strap alone.
// - the dram is aligned in a32 space to the full installed size as well.
// - vme byte offsets become local longword offsets by dividing by four.
// - while the host block bit (d4 of the host register at short base + 4) is 1, no dram access.
// - the a32 strap defaults to all zero, an a32 base of zero.
// - the host control register decodes in short space for modifiers 29 and 2d only.
// ----------------------------------------------------------------------------
package vdsd_pkg;

   // ----------------------------------------------------------------------------
   // address modifiers and spaces
   // ----------------------------------------------------------------------------
   localparam logic [5:0] AM_A16_USR = 6'h29;
   localparam logic [5:0] AM_A16_SUP = 6'h2D;

   typedef enum logic [1:0] {
      SP_NONE = 2'b00,
      SP_A16 = 2'b01,
      SP_A24 = 2'b11,
      SP_A32 = 2'b10
   } vdsd_space_e;

   // ----------------------------------------------------------------------------
   // window size strap codes, also the don't-care mask over a23..a20
   // ----------------------------------------------------------------------------
   localparam logic [3:0] WIN_1MB = 4'h0;
   localparam logic [3:0] WIN_2MB = 4'h1;
   localparam logic [3:0] WIN_4MB = 4'h3;
   localparam logic [3:0] WIN_8MB = 4'h7;
   localparam logic [3:0] WIN_16MB = 4'hF;

   // short-space host control register and its block bit
   localparam logic [15:0] HCR_OFFSET = 16'h0004;
   localparam int unsigned HCR_BLOCK_BIT = 4;

   // ----------------------------------------------------------------------------
   // wishbone register map
   // ----------------------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_BASES = 8'h08;
   localparam logic [7:0] REG_CLAIMS = 8'h0C;
   localparam int unsigned CTRL_ENABLE_BIT = 0;

   // ----------------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------------
   localparam logic [3:0] STRAP_WIN_RST = 4'h0;
   localparam logic [3:0] STRAP_A24_RST = 4'h0;
   localparam logic [7:0] STRAP_A32_RST = 8'h00;
   localparam logic CTRL_ENABLE_RST = 1'b1;
   localparam logic BLOCK_RST = 1'b0;

   // strap levels as seen on the pins (fitted jumper pulls a bit to 0)
   typedef struct packed {
      logic [3:0] window;
      logic [3:0] a24;
      logic [7:0] a32;
      logic [15:0] short_base;
   } vdsd_straps_s;

   // one vme slave address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [5:0] am;
      logic [31:0] addr;
      logic [15:0] data;
   } vdsd_vme_req_s;

   // decoder answer, one cycle after the address phase
   typedef struct packed {
      logic dram_claim;
      logic a32_claim;
      logic hcr_claim;
      logic [21:0] lw_addr;
   } vdsd_vme_rsp_s;

   // all state of the top module
   typedef struct packed {
      vdsd_straps_s straps;
      logic captured;
      logic block;
      logic enable;
      vdsd_vme_rsp_s rsp;
      logic [15:0] claims;
      logic ack;
      logic [31:0] rdata;
   } vdsd_state_s;

   // address modifier to space
   function automatic vdsd_space_e am_space(input logic [5:0] am);
      vdsd_space_e s;
      s = SP_NONE;
      if (am == AM_A16_USR || am == AM_A16_SUP) begin
         s = SP_A16;
      end else if (am[5:2] == 4'hE || am[5:2] == 4'hF) begin
         s = SP_A24;
      end else if (am[5:2] == 4'h2 || am[5:2] == 4'h3) begin
         s = SP_A32;
      end
      return s;
   endfunction : am_space

   // legal window code check
   function automatic logic win_legal(input logic [3:0] code);
      return code == WIN_1MB || code == WIN_2MB || code == WIN_4MB ||
             code == WIN_8MB || code == WIN_16MB;
   endfunction : win_legal

   // full installed size rounded up to a power of two, as a mask over a23..a20
   function automatic logic [3:0] full_mask(input int unsigned dram_mb);
      logic [3:0] m;
      if (dram_mb <= 1) begin
         m = WIN_1MB;
      end else if (dram_mb <= 2) begin
         m = WIN_2MB;
      end else if (dram_mb <= 4) begin
         m = WIN_4MB;
      end else if (dram_mb <= 8) begin
         m = WIN_8MB;
      end else begin
         m = WIN_16MB;
      end
      return m;
   endfunction : full_mask

endpackage : vdsd_pkg

// [verilog/vdsd_window_match.sv]
// window compare and longword offset for one address space
`timescale 1ns/1ps
module vdsd_window_match (
   input wire logic [31:0] addr_i,
   input wire logic [11:0] base_i,
   input wire logic [3:0] mask_i,
   input wire logic upper_i,
   output logic hit_o,
   output logic [21:0] lw_off_o
);
   import vdsd_pkg::*;

   logic [11:0] care;

   // a20..a23 under the window mask are free, a24..a31 only count in a32
   always_comb begin
      care = {{8{upper_i}}, ~mask_i};
      hit_o = ((addr_i[31:20] ^ base_i) & care) == 12'h000;
      lw_off_o = {addr_i[23:20] & mask_i, addr_i[19:2]};
   end

endmodule : vdsd_window_match

// [verilog/vdsd_top.sv]
// vme slave decoder placing the shared dram in a24 and a32 space
`timescale 1ns/1ps
module vdsd_top #(
   parameter int unsigned DRAM_MB = 4,
   parameter bit VARIANT = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire vdsd_pkg::vdsd_straps_s straps_i,
   input wire vdsd_pkg::vdsd_vme_req_s vme_i,
   output vdsd_pkg::vdsd_vme_rsp_s vme_o,
   output logic dram_block_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   import vdsd_pkg::*;

   localparam logic [3:0] FULL_MASK = full_mask(DRAM_MB);

   // ----------------------------------------------------------------------------
   // state and derived decode terms
   // ----------------------------------------------------------------------------
   vdsd_state_s st_r;
   vdsd_state_s st_nxt;
   vdsd_space_e spc;
   logic win_ok;
   logic [3:0] win_mask;
   logic [3:0] a32_mask;
   logic [11:0] a24_base;
   logic [11:0] a32_base;
   logic a24_err;
   logic a32_err;
   logic a24_hit;
   logic a32_hit;
   logic [21:0] a24_lw;
   logic [21:0] a32_lw;
   logic [15:0] hcr_addr;
   logic hcr_hit;
   logic claim_ok;
   logic wb_req;

   // an illegal window code falls back to the smallest window rather than guessing
   always_comb begin
      spc = am_space(vme_i.am);
      win_ok = win_legal(st_r.straps.window);
      win_mask = win_ok ? st_r.straps.window : WIN_1MB;
      a32_mask = VARIANT ? FULL_MASK : win_mask;
      a24_base = {8'h00, st_r.straps.a24};
      // the standard sum cannot carry, a24 only fills the low nibble, so a31..a24 equal the a32 strap
      if (VARIANT) begin
         a32_base = {st_r.straps.a32, 4'h0};
      end else begin
         a32_base = {st_r.straps.a32, 4'h0} + {8'h00, st_r.straps.a24};
      end
      // alignment follows full installed size, not the reduced window
      a24_err = (st_r.straps.a24 & FULL_MASK) != 4'h0;
      a32_err = (a32_base[3:0] & FULL_MASK) != 4'h0;
      // the host register sits one longword above the short-space base
      hcr_addr = st_r.straps.short_base + HCR_OFFSET;
      hcr_hit = vme_i.valid && st_r.captured && spc == SP_A16 &&
                vme_i.addr[15:2] == hcr_addr[15:2];
   end

   // ----------------------------------------------------------------------------
   // window compare, one per space
   // ----------------------------------------------------------------------------
   vdsd_window_match u_a24 (
      .addr_i(vme_i.addr),
      .base_i(a24_base),
      .mask_i(win_mask),
      .upper_i(1'b0),
      .hit_o(a24_hit),
      .lw_off_o(a24_lw)
   );

   vdsd_window_match u_a32 (
      .addr_i(vme_i.addr),
      .base_i(a32_base),
      .mask_i(a32_mask),
      .upper_i(1'b1),
      .hit_o(a32_hit),
      .lw_off_o(a32_lw)
   );

   // claim only a matching, aligned, unblocked a24/a32 address; all else stays silent
   assign claim_ok = vme_i.valid && st_r.captured && st_r.enable && !st_r.block &&
                     ((spc == SP_A24 && a24_hit && !a24_err) ||
                      (spc == SP_A32 && a32_hit && !a32_err));

   assign wb_req = wb_cyc_i && wb_stb_i && !st_r.ack;

   // ----------------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      // jumpers are read once after reset; a live change would move the window mid-cycle
      if (!st_r.captured) begin
         st_nxt.straps = straps_i;
         st_nxt.captured = 1'b1;
      end
      st_nxt.rsp.dram_claim = claim_ok;
      st_nxt.rsp.a32_claim = claim_ok && spc == SP_A32;
      st_nxt.rsp.hcr_claim = hcr_hit;
      if (claim_ok) begin
         st_nxt.rsp.lw_addr = (spc == SP_A32) ? a32_lw : a24_lw;
      end
      // only the vme host owns the block bit
      if (hcr_hit && vme_i.write) begin
         st_nxt.block = vme_i.data[HCR_BLOCK_BIT];
      end
      // counter write clears; a claim in the same cycle still counts
      if (wb_req && wb_we_i && wb_adr_i == REG_CLAIMS && wb_sel_i[0]) begin
         st_nxt.claims = {15'h0000, claim_ok};
      end else if (claim_ok) begin
         st_nxt.claims = st_r.claims + 16'h0001;
      end
      st_nxt.ack = wb_req;
      if (wb_req) begin
         st_nxt.rdata = 32'h0000_0000;
         unique case (wb_adr_i)
            REG_CTRL: begin
               st_nxt.rdata = {31'h0000_0000, st_r.enable};
               if (wb_we_i && wb_sel_i[0]) begin
                  st_nxt.enable = wb_dat_i[CTRL_ENABLE_BIT];
               end
            end
            REG_STATUS: begin
               // the top byte is unused and reads zero
               st_nxt.rdata = {8'h00, st_r.straps.a32, st_r.straps.a24, st_r.straps.window,
                               3'h0, a32_err, a24_err, win_ok, st_r.captured,
                               st_r.block};
            end
            REG_BASES: begin
               st_nxt.rdata = {12'h000, a24_base[3:0], 4'h0, a32_base};
            end
            REG_CLAIMS: begin
               st_nxt.rdata = {16'h0000, st_r.claims};
            end
            default: begin
               st_nxt.rdata = 32'h0000_0000; // unmapped reads zero, writes dropped
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
         st_r.straps.window <= STRAP_WIN_RST;
         st_r.straps.a24 <= STRAP_A24_RST;
         st_r.straps.a32 <= STRAP_A32_RST;
         st_r.enable <= CTRL_ENABLE_RST;
         st_r.block <= BLOCK_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // every output comes straight from the state register
   assign vme_o = st_r.rsp;
   assign dram_block_o = st_r.block;
   assign wb_dat_o = st_r.rdata;
   assign wb_ack_o = st_r.ack;

   // ----------------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------------
   // every check runs on the one clock and sleeps through reset
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_hcr_write;
      hcr_hit && vme_i.write;
   endsequence

   sequence s_block_follows;
      st_r.block == $past(vme_i.data[HCR_BLOCK_BIT]) ##1 st_r.block == $past(st_r.block);
   endsequence

   a_block_refuses: assert property (
      (st_r.block && !(hcr_hit && vme_i.write)) |=> !vme_o.dram_claim ##1 1'b1)
      else $error("dram claimed while block bit set");

   a_hcr_write_block: assert property (
      s_hcr_write ##1 !(hcr_hit && vme_i.write) |-> s_block_follows)
      else $error("block bit did not follow host register write");

   a_block_am_only: assert property (
      !$stable(st_r.block) |-> ($past(vme_i.am) == AM_A16_USR || $past(vme_i.am) == AM_A16_SUP))
      else $error("block bit changed outside short space modifiers");

   a_claim_space: assert property (
      vme_o.dram_claim |-> ($past(spc) == SP_A24 || $past(spc) == SP_A32) && $past(vme_i.valid))
      else $error("claim without a24 or a32 modifier");

   a_a24_align: assert property (
      (spc == SP_A24 && a24_err) |=> !vme_o.dram_claim)
      else $error("misaligned a24 base claimed a cycle");

   a_a24_window: assert property (
      (vme_o.dram_claim && !vme_o.a32_claim) |->
      ((($past(vme_i.addr[23:20]) ^ $past(st_r.straps.a24)) & ~$past(win_mask)) == 4'h0))
      else $error("a24 claim outside the window");

   a_lw_offset: assert property (
      vme_o.dram_claim |-> vme_o.lw_addr[17:0] == $past(vme_i.addr[19:2]))
      else $error("longword offset is not byte offset over four");

   a_a32_base_sum: assert property (
      (!VARIANT && st_r.captured) |->
      a32_base == ({st_r.straps.a32, 4'h0} + {8'h00, st_r.straps.a24}))
      else $error("standard a32 base is not the strap sum");

   a_a32_base_alone: assert property (
      (VARIANT && st_r.captured) |-> a32_base == {st_r.straps.a32, 4'h0})
      else $error("variant a32 base moved by a24 strap");

   a_a32_full_reach: assert property (
      (VARIANT && st_r.captured && st_r.enable && !st_r.block && vme_i.valid &&
       spc == SP_A32 && vme_i.addr[31:24] == st_r.straps.a32 &&
       (vme_i.addr[23:20] & ~FULL_MASK) == 4'h0 &&
       !(hcr_hit && vme_i.write)) |=> vme_o.dram_claim && vme_o.a32_claim)
      else $error("variant a32 space does not reach all dram");

   a_strap_capture: assert property (
      $fell(rst_i) |-> !st_r.captured ##1 st_r.captured && st_r.straps == $past(straps_i))
      else $error("straps not caught in the first cycle after reset");

   // ----------------------------------------------------------------------------
   // checks on the claim gates
   // ----------------------------------------------------------------------------

   // a phase in one of the two dram spaces
   sequence s_dram_phase;
      vme_i.valid && (spc == SP_A24 || spc == SP_A32);
   endsequence

   // an a32 base off the full-size boundary must never map the memory
   a_a32_align: assert property (
      (spc == SP_A32 && a32_err) |=> !vme_o.dram_claim)
      else $error("misaligned a32 base claimed a cycle");

   // software can switch the dram claims off, even for aligned hits
   a_enable_gate: assert property (
      s_dram_phase ##0 !st_r.enable |=> !vme_o.dram_claim)
      else $error("dram claimed while decoder disabled");

   // short-space and unknown modifiers never reach the memory
   a_other_space: assert property (
      (spc == SP_A16 || spc == SP_NONE) |=> !vme_o.dram_claim)
      else $error("dram claimed outside a24 and a32 space");

   // with no address phase the far side must see no answer at all
   a_idle_silent: assert property (
      !vme_i.valid |=> !vme_o.dram_claim && !vme_o.hcr_claim)
      else $error("answer given without an address phase");

   // an a24 claim needs a base on the full installed size boundary
   a_a24_base_set: assert property (
      (vme_o.dram_claim && !vme_o.a32_claim) |->
      ($past(st_r.straps.a24) & FULL_MASK) == 4'h0)
      else $error("a24 claim from a base off the full size boundary");

   // an unknown window code falls back to 1 MB, so all four bits must match
   a_win_fallback: assert property (
      (vme_o.dram_claim && !vme_o.a32_claim && !$past(win_ok)) |->
      $past(vme_i.addr[23:20]) == $past(st_r.straps.a24))
      else $error("a24 claim wider than 1 MB under an unknown window code");

   // the eight upper address bits of an a32 claim equal the a32 base
   a_a32_upper: assert property (
      vme_o.a32_claim |-> $past(vme_i.addr[31:24]) == $past(a32_base[11:4]))
      else $error("a32 claim with upper address bits off the base");

   // the local offset only moves with a claim, so a refused phase leaves it alone
   a_lw_hold: assert property (
      !vme_o.dram_claim |-> $stable(vme_o.lw_addr))
      else $error("longword offset moved without a claim");

   // ----------------------------------------------------------------------------
   // checks on the host register decode
   // ----------------------------------------------------------------------------

   // only the two short-space modifiers reach the host register
   a_hcr_modifier: assert property (
      vme_o.hcr_claim |-> ($past(vme_i.am) == AM_A16_USR || $past(vme_i.am) == AM_A16_SUP))
      else $error("host register hit with a wrong modifier");

   // the hit lands one longword above the short-space base, byte lanes ignored
   a_hcr_offset: assert property (
      vme_o.hcr_claim |->
      $past(vme_i.addr[15:2]) == 14'(($past(st_r.straps.short_base) + HCR_OFFSET) >> 2))
      else $error("host register hit at a wrong address");

endmodule : vdsd_top

// [verification/vdsd_vme_master.sv]
// behavioural vme master that presents address phases to the decoder
`timescale 1ns/1ps
module vdsd_vme_master
   import vdsd_pkg::*;
(
   input wire logic clk_i,
   output vdsd_pkg::vdsd_vme_req_s vme_o
);
   // bus idle at time zero
   initial begin
      vme_o = '0;
   end

   // one phase, then the lines are released with inverted values so that
   // a decoder leaning on stale address bits cannot pass by luck
   task automatic phase(input logic we, input logic [5:0] am, input logic [31:0] addr,
         input logic [15:0] data);
      @(posedge clk_i);
      vme_o <= '{valid: 1'b1, write: we, am: am, addr: addr, data: data};
      @(posedge clk_i);
      vme_o <= '{valid: 1'b0, write: ~we, am: ~am, addr: ~addr, data: ~data};
      #1;
   endtask : phase
endmodule : vdsd_vme_master

// [verification/vdsd_top_test.sv]
// self-checking bench for the vme dram slave decoder
`timescale 1ns/1ps
module vdsd_top_test;
   import vdsd_pkg::*;
   // ----------------------------------------------------------------------------
   // stimulus and instances
   // ----------------------------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   vdsd_straps_s straps = '{window: 4'h1, a24: 4'h4, a32: 8'h80, short_base: 16'h8000};
   vdsd_vme_req_s vme;
   vdsd_vme_rsp_s rsp;
   vdsd_vme_rsp_s rsp_v;
   logic blk;
   logic blk_v;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;

   // standard build with 4 MB, variant build with 8 MB on the same bus
   vdsd_top #(.DRAM_MB(4), .VARIANT(1'b0)) i_vdsd_top (.clk_i(clk_i), .rst_i(rst_i),
      .straps_i(straps), .vme_i(vme), .vme_o(rsp), .dram_block_o(blk), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack));
   vdsd_top #(.DRAM_MB(8), .VARIANT(1'b1)) i_vdsd_top_var (.clk_i(clk_i), .rst_i(rst_i),
      .straps_i(straps), .vme_i(vme), .vme_o(rsp_v), .dram_block_o(blk_v), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(), .wb_ack_o());
   vdsd_vme_master i_vdsd_vme_master (.clk_i(clk_i), .vme_o(vme));

   // 20 MHz clock
   always #25 clk_i = ~clk_i;

   // hang guard, the whole run needs about a hundred cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   // classic single cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) check("wb ack", 32'(ack), 32'h1);
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      check(n, q, e);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr

   // one dram phase, judged on both builds
   task automatic dec(input logic [5:0] am, input logic [31:0] addr, input logic c,
         input logic [21:0] lw, input logic cv, input logic [21:0] lwv);
      i_vdsd_vme_master.phase(1'b1, am, addr, 16'h1234);
      check("dram claim", 32'(rsp.dram_claim), 32'(c));
      check("a32 claim", 32'(rsp.a32_claim), 32'(c & (am[5:3] == 3'b001)));
      if (c) check("lw addr", 32'(rsp.lw_addr), 32'(lw));
      check("var claim", 32'(rsp_v.dram_claim), 32'(cv));
      if (cv) check("var lw addr", 32'(rsp_v.lw_addr), 32'(lwv));
   endtask : dec

   // reset held over several edges, then two idle edges for strap capture
   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : do_reset

   // ----------------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------------
   task automatic s_regs();
      rd(REG_STATUS, 32'h0080_4106, "status");
      rd(REG_BASES, 32'h0004_0804, "bases");
      rd(REG_CTRL, 32'h1, "ctrl");
      wr(8'h10, 32'hFFFF_FFFF);
      rd(8'h10, 32'h0, "unmapped");
      wr(REG_STATUS, 32'h0000_00FF);
      rd(REG_STATUS, 32'h0080_4106, "status ro");
   endtask : s_regs

   task automatic s_decode();
      dec(6'h39, 32'h005A_BCD7, 1'b1, 22'h06AF35, 1'b0, 22'h0);
      dec(6'h3D, 32'h006A_BCD7, 1'b0, 22'h0, 1'b0, 22'h0);
      dec(6'h09, 32'h8040_0010, 1'b1, 22'h000004, 1'b1, 22'h100004);
      dec(6'h0D, 32'h8060_0010, 1'b0, 22'h0, 1'b1, 22'h180004);
      dec(6'h0B, 32'h8000_0010, 1'b0, 22'h0, 1'b1, 22'h000004);
      dec(6'h29, 32'h005A_BCD7, 1'b0, 22'h0, 1'b0, 22'h0);
   endtask : s_decode

   task automatic s_block();
      i_vdsd_vme_master.phase(1'b1, 6'h3D, 32'h0000_8004, 16'h0010);
      check("hcr claim", 32'(rsp.hcr_claim), 32'h0);
      check("block", 32'(blk), 32'h0);
      i_vdsd_vme_master.phase(1'b1, AM_A16_USR, 32'h0000_8004, 16'h0010);
      check("hcr claim", 32'(rsp.hcr_claim), 32'h1);
      check("block", 32'(blk), 32'h1);
      check("var block", 32'(blk_v), 32'h1);
      dec(6'h39, 32'h005A_BCD7, 1'b0, 22'h0, 1'b0, 22'h0);
      dec(6'h09, 32'h8000_0010, 1'b0, 22'h0, 1'b0, 22'h0);
      rd(REG_STATUS, 32'h0080_4107, "status block");
      i_vdsd_vme_master.phase(1'b1, AM_A16_SUP, 32'h0000_8004, 16'h0000);
      check("block", 32'(blk), 32'h0);
      dec(6'h39, 32'h005A_BCD7, 1'b1, 22'h06AF35, 1'b0, 22'h0);
   endtask : s_block

   task automatic s_claims();
      wr(REG_CLAIMS, 32'h1);
      rd(REG_CLAIMS, 32'h0, "claims clear");
      dec(6'h3A, 32'h0040_0000, 1'b1, 22'h0, 1'b0, 22'h0);
      dec(6'h0F, 32'h805F_FFFC, 1'b1, 22'h07FFFF, 1'b1, 22'h17FFFF);
      rd(REG_CLAIMS, 32'h2, "claims");
      wr(REG_CTRL, 32'h0);
      dec(6'h39, 32'h005A_BCD7, 1'b0, 22'h0, 1'b0, 22'h0);
      wr(REG_CTRL, 32'h1);
      rd(REG_CTRL, 32'h1, "ctrl");
   endtask : s_claims

   // a24 base off the full-size boundary in both builds; variant a32 stays aligned
   task automatic s_misalign();
      straps.a24 <= 4'h2;
      do_reset();
      rd(REG_STATUS, 32'h0080_211E, "status misaligned");
      rd(REG_BASES, 32'h0002_0802, "bases");
      dec(6'h39, 32'h002A_BCD7, 1'b0, 22'h0, 1'b0, 22'h0);
      dec(6'h09, 32'h8020_0010, 1'b0, 22'h0, 1'b1, 22'h080004);
   endtask : s_misalign

   task automatic wrap_up();
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up

   // main sequence
   initial begin
      do_reset();
      s_regs();
      s_decode();
      s_block();
      s_claims();
      s_misalign();
      wrap_up();
   end
endmodule : vdsd_top_test
